// >>> verilog/mpu_cfg.svh
`ifndef MPU_CFG_SVH
`define MPU_CFG_SVH

// Region count and register window
`define MPU_NUM_REGIONS 8
`define MPU_BG_REGION 4'h8
`define MPU_SEL_ADDR 32'hE000ED98
`define MPU_BASE_OFS 32'h00000004
`define MPU_ATTR_OFS 32'h00000008
`define MPU_MAP_BYTES 32'h00000024

// Base-address register fields
`define MPU_BASE_ADDR_LSB 5
`define MPU_BASE_VALID_BIT 4
`define MPU_BASE_RGN_LSB 0

// Attribute-and-size register fields
`define MPU_ATTR_XN_BIT 28
`define MPU_ATTR_AP_LSB 24
`define MPU_ATTR_TEX_LSB 19
`define MPU_ATTR_C_BIT 17
`define MPU_ATTR_B_BIT 16
`define MPU_ATTR_SRD_LSB 8
`define MPU_ATTR_SIZE_LSB 1
`define MPU_ATTR_EN_BIT 0
`define MPU_ATTR_MASK 32'h17FFFF3F

// Reset values
`define MPU_ATTR_RST 32'h00000000
`define MPU_BASE_RST 27'h0000000
`define MPU_SEL_RST 3'h0

// Size field limits
`define MPU_SIZE_MIN 5'h04
`define MPU_SIZE_SUBRGN 5'h07

// Permission encodings
`define MPU_AP_NONE 3'h0
`define MPU_AP_PRIV_RW 3'h1
`define MPU_AP_USER_RO 3'h2
`define MPU_AP_FULL 3'h3
`define MPU_AP_RSVD 3'h4
`define MPU_AP_PRIV_RO 3'h5
`define MPU_AP_RO 3'h6
`define MPU_AP_RO_ALT 3'h7

`endif

// >>> verilog/mpu_pkg.sv
package mpu_pkg;

  typedef enum logic [1:0] {
    MPU_MEM_STRONG,
    MPU_MEM_DEVICE,
    MPU_MEM_NORMAL
  } mpu_mem_t;

  typedef enum logic [1:0] {
    MPU_SZ_BYTE,
    MPU_SZ_HALF,
    MPU_SZ_WORD,
    MPU_SZ_RSVD
  } mpu_xfer_size_t;

  typedef enum logic [1:0] {
    MPU_REG_NONE,
    MPU_REG_SELECT,
    MPU_REG_BASE,
    MPU_REG_ATTR
  } mpu_reg_t;

endpackage

// >>> verilog/mpu_region_if.sv
`timescale 1ns/1ps
interface mpu_region_if;
  logic [26:0] base;
  logic [4:0] size;
  logic [7:0] subregion_disable_mask;
  logic en;
  logic [31:0] addr;
  logic hit;

  modport cfg (output base, output size, output subregion_disable_mask, output en, output addr, input hit);
  modport match (input base, input size, input subregion_disable_mask, input en, input addr, output hit);
endinterface

// >>> verilog/mpu_region_match.sv
`timescale 1ns/1ps
`include "mpu_cfg.svh"
module mpu_region_match (
  mpu_region_if.match rgn
);
  logic [5:0] span;
  logic [5:0] sub_shift;
  logic [31:0] low_mask;
  logic [31:0] base_full;
  logic [31:0] sub_word;
  logic in_range;
  logic sub_off;

  // Region spans two to the power size+1 bytes
  assign span = {1'h0, rgn.size} + 6'h01;
  assign low_mask = (span >= 6'h20) ? 32'hFFFFFFFF : ((32'h00000001 << span) - 32'h00000001);
  assign base_full = {rgn.base, 5'h00};
  assign in_range = ((rgn.addr ^ base_full) & ~low_mask) == 32'h00000000;

  // Eighth of the region: bit 0 is the lowest subregion
  assign sub_shift = span - 6'h03;
  assign sub_word = rgn.addr >> sub_shift;
  assign sub_off = (rgn.size >= `MPU_SIZE_SUBRGN) && rgn.subregion_disable_mask[sub_word[2:0]];

  // A disabled subregion simply misses, letting others or the background decide
  assign rgn.hit = rgn.en && (rgn.size >= `MPU_SIZE_MIN) && in_range && !sub_off;
endmodule

// >>> verilog/mpu_perm_check.sv
`timescale 1ns/1ps
`include "mpu_cfg.svh"
module mpu_perm_check (
  input wire logic [2:0] ap,
  input wire logic priv,
  input wire logic write,
  output logic allow
);
  always_comb begin
    case (ap)
      `MPU_AP_NONE: allow = 1'b0;
      `MPU_AP_PRIV_RW: allow = priv;
      `MPU_AP_USER_RO: allow = priv || !write;
      `MPU_AP_FULL: allow = 1'b1;
      `MPU_AP_PRIV_RO: allow = priv && !write;
      `MPU_AP_RO: allow = !write;
      `MPU_AP_RO_ALT: allow = !write;
      // Reserved encoding is treated as no access
      default: allow = 1'b0;
    endcase
  end
endmodule

// >>> verilog/mpu_top.sv
// What this block does
// - Eight regions zero to seven, plus background
// - Highest numbered matching region wins
// - Background allowed for privileged accesses only
// - Fetches and data share one region table
// - Prohibited access raises memory-management fault
// - Strongly ordered regions keep strict program order
// - Attribute register takes byte, half, word writes
// - Select, base, attribute at fixed word offsets
// - Separate writes or consecutive burst both accepted
// - Valid base write also loads region select
// - Alias copies of base and attribute decoded
// - Large regions split into eight disable-able subregions
// - Subregion disable bit zero is lowest subregion
// - Disabled subregion falls to other region or background
// - Register updates apply strictly in issue order
// - Exception entry and return act as barriers
// - Permission field: zero denies, three full access
`timescale 1ns/1ps
`include "mpu_cfg.svh"
module mpu_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic ppb_sel,
  input wire logic ppb_write,
  input wire logic [31:0] ppb_addr,
  input wire mpu_pkg::mpu_xfer_size_t ppb_size,
  input wire logic [31:0] ppb_wdata,
  output logic ppb_rvalid,
  output logic [31:0] ppb_rdata,
  output logic ppb_err,
  input wire logic exc_barrier,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_priv,
  input wire logic acc_fetch,
  output logic acc_ready,
  output logic res_valid,
  output logic res_fault,
  output logic [3:0] res_region,
  output mpu_pkg::mpu_mem_t res_mem_type,
  output logic res_strong_order
);
  localparam int NR = `MPU_NUM_REGIONS;

  // Register file state
  logic [2:0] select_r;
  logic [2:0] select_nxt;
  logic [26:0] base_r [NR];
  logic [26:0] base_nxt [NR];
  logic [31:0] attr_r [NR];
  logic [31:0] attr_nxt [NR];
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic err_r;
  logic err_nxt;

  // Bus decode
  logic [31:0] ofs;
  logic [3:0] word_idx;
  logic in_map;
  logic aligned;
  logic legal;
  logic [3:0] lane_en;
  logic [31:0] lane_mask;
  logic [2:0] wr_rgn;
  mpu_pkg::mpu_reg_t reg_kind;

  assign ofs = ppb_addr - `MPU_SEL_ADDR;
  assign word_idx = ofs[5:2];
  assign in_map = ofs < `MPU_MAP_BYTES;

  // Word 0 is select; odd words are base and its aliases, even words attribute and aliases
  always_comb begin
    if (!in_map) begin
      reg_kind = mpu_pkg::MPU_REG_NONE;
    end else if (word_idx == 4'h0) begin
      reg_kind = mpu_pkg::MPU_REG_SELECT;
    end else if (word_idx[0] == 1'((`MPU_BASE_OFS >> 2) & 32'h00000001)) begin
      reg_kind = mpu_pkg::MPU_REG_BASE;
    end else begin
      reg_kind = mpu_pkg::MPU_REG_ATTR;
    end
  end

  always_comb begin
    case (ppb_size)
      mpu_pkg::MPU_SZ_BYTE: begin
        aligned = 1'b1;
        lane_en = 4'h1 << ppb_addr[1:0];
      end
      mpu_pkg::MPU_SZ_HALF: begin
        aligned = !ppb_addr[0];
        lane_en = ppb_addr[1] ? 4'hC : 4'h3;
      end
      mpu_pkg::MPU_SZ_WORD: begin
        aligned = ppb_addr[1:0] == 2'h0;
        lane_en = 4'hF;
      end
      default: begin
        aligned = 1'b0;
        lane_en = 4'h0;
      end
    endcase
  end

  // Narrow select or base access, or unaligned access, is answered with an error and changes nothing
  assign legal = (reg_kind != mpu_pkg::MPU_REG_NONE) && aligned &&
                 ((reg_kind == mpu_pkg::MPU_REG_ATTR) || (ppb_size == mpu_pkg::MPU_SZ_WORD));
  assign lane_mask = {{8{lane_en[3]}}, {8{lane_en[2]}}, {8{lane_en[1]}}, {8{lane_en[0]}}};
  assign wr_rgn = ppb_wdata[`MPU_BASE_VALID_BIT] ? ppb_wdata[`MPU_BASE_RGN_LSB +: 3] : select_r;

  // One write per cycle lands immediately, so back-to-back stores keep issue order
  always_comb begin
    select_nxt = select_r;
    base_nxt = base_r;
    attr_nxt = attr_r;
    if (ppb_sel && ppb_write && legal) begin
      case (reg_kind)
        mpu_pkg::MPU_REG_SELECT: select_nxt = ppb_wdata[2:0];
        mpu_pkg::MPU_REG_BASE: begin
          select_nxt = wr_rgn;
          base_nxt[wr_rgn] = ppb_wdata[31:`MPU_BASE_ADDR_LSB];
        end
        mpu_pkg::MPU_REG_ATTR: begin
          attr_nxt[select_r] = ((attr_r[select_r] & ~lane_mask) | (ppb_wdata & lane_mask)) &
                               `MPU_ATTR_MASK;
        end
        default: select_nxt = select_r;
      endcase
    end
  end

  always_comb begin
    rvalid_nxt = ppb_sel;
    err_nxt = ppb_sel && !legal;
    rdata_nxt = rdata_r;
    if (ppb_sel && !ppb_write && legal) begin
      case (reg_kind)
        mpu_pkg::MPU_REG_SELECT: rdata_nxt = {29'h0, select_r};
        // Valid flag always reads back as zero
        mpu_pkg::MPU_REG_BASE: rdata_nxt = {base_r[select_r], 2'h0, select_r};
        mpu_pkg::MPU_REG_ATTR: rdata_nxt = attr_r[select_r];
        default: rdata_nxt = 32'h00000000;
      endcase
    end else if (ppb_sel) begin
      rdata_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      select_r <= `MPU_SEL_RST;
      for (int i = 0; i < NR; i++) begin
        base_r[i] <= `MPU_BASE_RST;
        attr_r[i] <= `MPU_ATTR_RST;
      end
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else begin
      select_r <= select_nxt;
      base_r <= base_nxt;
      attr_r <= attr_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign ppb_rvalid = rvalid_r;
  assign ppb_rdata = rdata_r;
  assign ppb_err = err_r;

  // Region matchers, one per region
  logic [NR-1:0] hit;
  mpu_region_if rif [NR] ();

  for (genvar g = 0; g < NR; g++) begin : g_rgn
    assign rif[g].base = base_r[g];
    assign rif[g].size = attr_r[g][`MPU_ATTR_SIZE_LSB +: 5];
    assign rif[g].subregion_disable_mask = attr_r[g][`MPU_ATTR_SRD_LSB +: 8];
    assign rif[g].en = attr_r[g][`MPU_ATTR_EN_BIT];
    assign rif[g].addr = acc_addr;
    mpu_region_match u_match (
      .rgn(rif[g])
    );
    assign hit[g] = rif[g].hit;
  end

  // Winner selection
  logic any_hit;
  logic [2:0] win;
  logic [31:0] win_attr;

  always_comb begin
    any_hit = 1'b0;
    win = 3'h0;
    for (int i = 0; i < NR; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win = i[2:0];
      end
    end
  end

  assign win_attr = attr_r[win];

  logic perm_ok;
  mpu_perm_check u_perm (
    .ap(win_attr[`MPU_ATTR_AP_LSB +: 3]),
    .priv(acc_priv),
    .write(acc_write),
    .allow(perm_ok)
  );

  // Memory type of the winning region or of the default map
  logic [2:0] tex;
  logic attr_c;
  logic attr_b;
  logic bg_xn;
  logic allowed;
  mpu_pkg::mpu_mem_t mem_type;

  assign tex = win_attr[`MPU_ATTR_TEX_LSB +: 3];
  assign attr_c = win_attr[`MPU_ATTR_C_BIT];
  assign attr_b = win_attr[`MPU_ATTR_B_BIT];

  always_comb begin
    bg_xn = 1'b0;
    if (any_hit) begin
      if (tex == 3'h0 && !attr_c && !attr_b) begin
        mem_type = mpu_pkg::MPU_MEM_STRONG;
      end else if ((tex == 3'h0 && !attr_c && attr_b) || (tex == 3'h2 && !attr_c && !attr_b)) begin
        mem_type = mpu_pkg::MPU_MEM_DEVICE;
      end else begin
        mem_type = mpu_pkg::MPU_MEM_NORMAL;
      end
      allowed = perm_ok && !(acc_fetch && win_attr[`MPU_ATTR_XN_BIT]);
    end else begin
      // Default map by top address bits; device and system space never execute
      case (acc_addr[31:29])
        3'h2, 3'h5, 3'h6: mem_type = mpu_pkg::MPU_MEM_DEVICE;
        3'h7: mem_type = mpu_pkg::MPU_MEM_STRONG;
        default: mem_type = mpu_pkg::MPU_MEM_NORMAL;
      endcase
      bg_xn = mem_type != mpu_pkg::MPU_MEM_NORMAL;
      allowed = acc_priv && !(acc_fetch && bg_xn);
    end
  end

  // Stalling while exc_barrier is high at an exception boundary lets any register write settle first
  assign acc_ready = !exc_barrier;

  // Result stage
  logic res_valid_r;
  logic res_valid_nxt;
  logic res_fault_r;
  logic res_fault_nxt;
  logic [3:0] res_region_r;
  logic [3:0] res_region_nxt;
  mpu_pkg::mpu_mem_t res_mem_r;
  mpu_pkg::mpu_mem_t res_mem_nxt;

  always_comb begin
    res_valid_nxt = acc_valid && acc_ready;
    res_fault_nxt = 1'b0;
    res_region_nxt = res_region_r;
    res_mem_nxt = res_mem_r;
    if (acc_valid && acc_ready) begin
      res_fault_nxt = !allowed;
      res_region_nxt = any_hit ? {1'h0, win} : `MPU_BG_REGION;
      res_mem_nxt = mem_type;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_valid_r <= 1'b0;
      res_fault_r <= 1'b0;
      res_region_r <= `MPU_BG_REGION;
      res_mem_r <= mpu_pkg::MPU_MEM_NORMAL;
    end else begin
      res_valid_r <= res_valid_nxt;
      res_fault_r <= res_fault_nxt;
      res_region_r <= res_region_nxt;
      res_mem_r <= res_mem_nxt;
    end
  end

  assign res_valid = res_valid_r;
  assign res_fault = res_fault_r;
  assign res_region = res_region_r;
  assign res_mem_type = res_mem_r;
  // Core must not reorder or merge while this flag is set
  assign res_strong_order = res_mem_r == mpu_pkg::MPU_MEM_STRONG;
endmodule

// >>> sim/mpu_top_chk.sv
`timescale 1ns/1ps
module mpu_top_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic ppb_sel,
  input wire logic [31:0] ppb_addr,
  input wire mpu_pkg::mpu_xfer_size_t ppb_size,
  input wire logic ppb_rvalid,
  input wire logic [31:0] ppb_rdata,
  input wire logic ppb_err,
  input wire logic exc_barrier,
  input wire logic acc_valid,
  input wire logic acc_priv,
  input wire logic acc_ready,
  input wire logic res_valid,
  input wire logic res_fault,
  input wire logic [3:0] res_region,
  input wire mpu_pkg::mpu_mem_t res_mem_type,
  input wire logic res_strong_order
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ans; ppb_sel |=> ppb_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("register answer missing");
  property p_idle; !ppb_sel |=> !ppb_rvalid && !ppb_err; endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_rsv; ppb_sel && ppb_size == mpu_pkg::MPU_SZ_RSVD |=> ppb_err; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved size accepted");
  property p_algn; ppb_sel && ppb_size == mpu_pkg::MPU_SZ_WORD && ppb_addr[1:0] != 2'h0 |=> ppb_err; endproperty
  a_algn: assert property (p_algn) else $error("unaligned word accepted");
  property p_ezero; ppb_err |-> ppb_rvalid && ppb_rdata == 32'h0; endproperty
  a_ezero: assert property (p_ezero) else $error("error answer carries data");
  property p_rdy; acc_ready != exc_barrier; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not tied to barrier");
  property p_res; acc_valid && acc_ready |=> res_valid; endproperty
  a_res: assert property (p_res) else $error("check result missing");
  property p_stall; !(acc_valid && acc_ready) |=> !res_valid; endproperty
  a_stall: assert property (p_stall) else $error("result without accepted check");
  property p_so; res_strong_order == (res_mem_type == mpu_pkg::MPU_MEM_STRONG); endproperty
  a_so: assert property (p_so) else $error("order flag disagrees with type");
  property p_bg; res_valid && res_region == 4'h8 && !$past(acc_priv) |-> res_fault; endproperty
  a_bg: assert property (p_bg) else $error("unprivileged background allowed");
  property p_rgn; res_valid |-> res_region <= 4'h8; endproperty
  a_rgn: assert property (p_rgn) else $error("region number out of range");
  c_err: cover property (ppb_err);
  c_dev: cover property (res_valid && res_mem_type == mpu_pkg::MPU_MEM_DEVICE);
  c_flt: cover property (res_valid && res_fault);
  c_bg: cover property (res_valid && res_region == 4'h8);
endmodule
bind mpu_top mpu_top_chk chk (.clk(clk), .srst(srst), .ppb_sel(ppb_sel), .ppb_addr(ppb_addr), .ppb_size(ppb_size),
  .ppb_rvalid(ppb_rvalid), .ppb_rdata(ppb_rdata), .ppb_err(ppb_err), .exc_barrier(exc_barrier),
  .acc_valid(acc_valid), .acc_priv(acc_priv), .acc_ready(acc_ready), .res_valid(res_valid),
  .res_fault(res_fault), .res_region(res_region), .res_mem_type(res_mem_type), .res_strong_order(res_strong_order));

// >>> sim/mpu_core_model.sv
`timescale 1ns/1ps
module mpu_core_model (
  input wire logic clk,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_write,
  output logic acc_priv,
  output logic acc_fetch,
  input wire logic acc_ready,
  input wire logic res_valid,
  input wire logic res_fault,
  input wire logic [3:0] res_region,
  input wire mpu_pkg::mpu_mem_t res_mem_type
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_write = 1'b0;
    acc_priv = 1'b0;
    acc_fetch = 1'b0;
  end

  // Fetches and data share this one port
  task automatic chk(input logic [31:0] a, input logic w, p, fe, output logic flt, output logic [3:0] rg,
                     output mpu_pkg::mpu_mem_t mt);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_write <= w;
    acc_priv <= p;
    acc_fetch <= fe;
    @(posedge clk);
    while (!acc_ready) @(posedge clk);
    acc_valid <= 1'b0;
    // Stale address would hide a design that ignores valid
    acc_addr <= ~a;
    @(negedge clk);
    flt = res_valid ? res_fault : 1'bx;
    rg = res_region;
    mt = res_mem_type;
  endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, srst, ppb_sel, ppb_write, ppb_rvalid, ppb_err, exc_barrier;
  logic [31:0] ppb_addr, ppb_wdata, ppb_rdata, acc_addr;
  mpu_pkg::mpu_xfer_size_t ppb_size;
  logic acc_valid, acc_write, acc_priv, acc_fetch, acc_ready, res_valid, res_fault, res_strong_order;
  logic [3:0] res_region, r;
  mpu_pkg::mpu_mem_t res_mem_type, m;
  logic f;
  int errors, n_compared;
  localparam logic [31:0] SEL = 32'hE000ED98;
  localparam mpu_pkg::mpu_xfer_size_t BY = mpu_pkg::MPU_SZ_BYTE;
  localparam mpu_pkg::mpu_xfer_size_t HF = mpu_pkg::MPU_SZ_HALF;
  localparam mpu_pkg::mpu_xfer_size_t WD = mpu_pkg::MPU_SZ_WORD;

  mpu_top uut (.clk(clk), .srst(srst), .ppb_sel(ppb_sel), .ppb_write(ppb_write), .ppb_addr(ppb_addr),
    .ppb_size(ppb_size), .ppb_wdata(ppb_wdata), .ppb_rvalid(ppb_rvalid), .ppb_rdata(ppb_rdata),
    .ppb_err(ppb_err), .exc_barrier(exc_barrier), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_write(acc_write), .acc_priv(acc_priv), .acc_fetch(acc_fetch), .acc_ready(acc_ready),
    .res_valid(res_valid), .res_fault(res_fault), .res_region(res_region), .res_mem_type(res_mem_type),
    .res_strong_order(res_strong_order));
  mpu_core_model core (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_priv(acc_priv), .acc_fetch(acc_fetch), .acc_ready(acc_ready), .res_valid(res_valid),
    .res_fault(res_fault), .res_region(res_region), .res_mem_type(res_mem_type));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input mpu_pkg::mpu_xfer_size_t sz,
                     input logic [31:0] d, input logic ee, input logic [31:0] er);
    @(posedge clk);
    ppb_sel <= 1'b1;
    ppb_write <= w;
    ppb_addr <= a;
    ppb_size <= sz;
    ppb_wdata <= d;
    @(posedge clk);
    ppb_sel <= 1'b0;
    ppb_addr <= ~a;
    @(negedge clk);
    check("rvalid", ppb_rvalid, 1'b1);
    check("err", ppb_err, ee);
    if (!w) check("rdata", ppb_rdata, er);
  endtask

  // Back-to-back word writes, as a multi-word store issues them
  task automatic burst(input logic [31:0] a0, input logic [31:0] d0, d1, d2, input int n);
    logic [31:0] dv [3];
    dv = '{d0, d1, d2};
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ppb_sel <= 1'b1;
      ppb_write <= 1'b1;
      ppb_size <= WD;
      ppb_addr <= a0 + 32'(4 * i);
      ppb_wdata <= dv[i];
    end
    @(posedge clk);
    ppb_sel <= 1'b0;
    @(negedge clk);
    check("burst err", ppb_err, 1'b0);
  endtask

  task automatic acc(input logic [31:0] a, input logic w, p, fe, input logic ef, input logic [3:0] er);
    core.chk(a, w, p, fe, f, r, m);
    check("fault", f, ef);
    check("region", r, er);
  endtask

  // No check runs while a region's attributes change; region is off meanwhile
  task automatic reattr(input logic [31:0] a, input logic [31:0] d);
    bus(1, SEL + 8, BY, 32'h00000008, 0, 0);
    bus(1, a, BY, d, 0, 0);
    bus(1, SEL + 8, BY, 32'h00000009, 0, 0);
  endtask

  task automatic t_regs;
    bus(0, SEL, WD, 0, 0, 0);
    bus(0, SEL + 8, WD, 0, 0, 0);
    bus(1, SEL, WD, 3, 0, 0);
    bus(0, SEL + 4, WD, 0, 0, 3);
    bus(1, SEL + 4, WD, 32'h20000015, 0, 0);
    bus(0, SEL, WD, 0, 0, 5);
    bus(0, SEL + 4, WD, 0, 0, 32'h20000005);
    bus(1, SEL + 9, BY, 32'h0000AB00, 0, 0);
    bus(1, SEL + 10, HF, 32'h03000000, 0, 0);
    bus(0, SEL + 8, WD, 0, 0, 32'h0300AB00);
    bus(1, SEL + 9, HF, 32'h00FFFF00, 1, 0);
    bus(1, SEL, HF, 0, 1, 0);
    bus(0, SEL + 32'h24, WD, 0, 1, 0);
    bus(0, SEL + 8, mpu_pkg::MPU_SZ_RSVD, 0, 1, 0);
    bus(0, SEL + 8, WD, 0, 0, 32'h0300AB00);
    bus(1, SEL + 8, WD, 0, 0, 0);
    $display("register test done");
  endtask

  task automatic t_map;
    burst(SEL, 0, 32'h20000000, 32'h13028017, 3);
    burst(SEL + 12, 32'h20000015, 32'h00000113, 0, 2);
    acc(32'h20000080, 0, 0, 0, 1, 5);
    check("type", m, mpu_pkg::MPU_MEM_STRONG);
    check("order", res_strong_order, 1'b1);
    acc(32'h20000010, 0, 0, 0, 0, 0);
    check("type", m, mpu_pkg::MPU_MEM_NORMAL);
    check("order", res_strong_order, 1'b0);
    acc(32'h20000800, 1, 0, 0, 0, 0);
    acc(32'h20000800, 0, 1, 1, 1, 0);
    acc(32'h20000F00, 0, 0, 0, 1, 8);
    acc(32'h20000F00, 0, 1, 0, 0, 8);
    acc(32'h30000000, 0, 0, 0, 1, 8);
    bus(1, SEL + 8, BY, 32'h00000012, 0, 0);
    bus(0, SEL + 8, WD, 0, 0, 32'h00000112);
    acc(32'h20000080, 0, 0, 0, 0, 0);
    $display("region test done");
  endtask

  // Region 7 is a 32-byte device window; walks permission codes 1, 2 and 4 to 7
  task automatic t_perm;
    bus(1, SEL + 8, WD, 0, 0, 0);
    bus(1, SEL + 4, WD, 32'h40000017, 0, 0);
    bus(1, SEL + 8, WD, 32'h01010009, 0, 0);
    acc(32'h4000001C, 0, 0, 0, 1, 7);
    acc(32'h4000001C, 1, 1, 0, 0, 7);
    check("type", m, mpu_pkg::MPU_MEM_DEVICE);
    acc(32'h40000020, 0, 1, 0, 0, 8);
    check("type", m, mpu_pkg::MPU_MEM_DEVICE);
    acc(32'h40000020, 0, 1, 1, 1, 8);
    acc(32'hE0000000, 0, 1, 0, 0, 8);
    check("type", m, mpu_pkg::MPU_MEM_STRONG);
    check("order", res_strong_order, 1'b1);
    reattr(SEL + 11, 32'h02000000);
    acc(32'h40000000, 1, 0, 0, 1, 7);
    acc(32'h40000000, 0, 0, 0, 0, 7);
    reattr(SEL + 11, 32'h04000000);
    acc(32'h40000000, 0, 1, 0, 1, 7);
    reattr(SEL + 11, 32'h05000000);
    acc(32'h40000000, 0, 1, 0, 0, 7);
    acc(32'h40000000, 1, 1, 0, 1, 7);
    acc(32'h40000000, 0, 0, 0, 1, 7);
    reattr(SEL + 11, 32'h06000000);
    acc(32'h40000000, 0, 0, 0, 0, 7);
    acc(32'h40000000, 1, 1, 0, 1, 7);
    reattr(SEL + 11, 32'h07000000);
    acc(32'h40000000, 0, 0, 0, 0, 7);
    acc(32'h40000000, 1, 0, 0, 1, 7);
    reattr(SEL + 10, 32'h00100000);
    acc(32'h40000000, 0, 1, 0, 0, 7);
    check("type", m, mpu_pkg::MPU_MEM_DEVICE);
    $display("permission test done");
  endtask

  task automatic t_barrier;
    fork
      begin
        @(posedge clk);
        exc_barrier <= 1'b1;
        @(negedge clk);
        check("ready", acc_ready, 1'b0);
        repeat (2) @(posedge clk);
        exc_barrier <= 1'b0;
      end
      acc(32'h20000010, 1, 1, 0, 0, 0);
    join
    $display("barrier test done");
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    srst = 1'b1;
    ppb_sel = 1'b0;
    ppb_write = 1'b0;
    ppb_addr = 32'h0;
    ppb_size = WD;
    ppb_wdata = 32'h0;
    exc_barrier = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_map();
    t_perm();
    t_barrier();
    print_verdict();
  end

  // Whole run needs under 150 cycles
  initial begin
    #20000;
    errors++;
    print_verdict();
  end
endmodule
